// file: dv/nvsc_dev_model.sv
// Purpose: Behavioural nonvolatile SRAM device facing the host
// Assumes: Busy pin pulled up; host drives all pins
// Notes: Transfer times shortened; undriven data shows inverted contents
`timescale 1ns/100ps
`default_nettype none
module nvsc_dev_model
  import nvsc_pkg::*;
#(
  parameter int STORE_NS = 2000 // Store length, shortened
) (
  // Memory pins from the host
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [14:0] addr_i,
  input wire logic [7:0] dq_i,
  // Supply trip and device side
  input wire logic trip_i,
  output logic [7:0] dq_o,
  output logic busy_n_o = 1'b1,
  output int store_cnt_o = 0,
  output int recall_cnt_o = 0
);
  logic [7:0] sram [32768]; // Volatile cells
  logic [7:0] nv [32768]; // Nonvolatile copy
  logic [13:0] seq [5] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4}; // Unlock order
  int step = 0; // Sequence reads matched
  logic dirty = 1'b0; // Written since last transfer
  logic xfer = 1'b0; // Transfer running
  logic wcyc = 1'b0; // This cycle is a write
  // Power-up recall of a blank array
  initial begin
    foreach (nv[i]) nv[i] = 8'h00;
    sram = nv;
  end
  // Released data shows the inverse, never a stale copy
  assign dq_o = (!ce_n_i && !oe_n_i && we_n_i && busy_n_o && !xfer) ? sram[addr_i] : ~sram[addr_i];
  // Mark write cycles at their start
  always @(negedge ce_n_i) wcyc = !we_n_i;
  always @(negedge we_n_i) wcyc = 1'b1;
  // Write commit or sequence step at the end of a cycle
  always @(posedge we_n_i or posedge ce_n_i) begin
    if (wcyc) begin
      if (busy_n_o && !xfer) begin
        sram[addr_i] = dq_i;
        dirty = 1'b1;
      end
      step = 0;
      wcyc = 1'b0;
    end else if (ce_n_i && busy_n_o && !xfer) begin
      if (step == 5) begin
        if (addr_i[13:0] == SEQ_STORE) fork nv_op(1'b1); join_none
        else if (addr_i[13:0] == SEQ_RECALL) fork nv_op(1'b0); join_none
        step = 0;
      end else step = (addr_i[13:0] == seq[step]) ? step + 1 : int'(addr_i[13:0] == SEQ_A0);
    end
  end
  // Store holds busy low to the end; recall is quiet
  task automatic nv_op(input logic st);
    xfer = 1'b1;
    if (st) busy_n_o = 1'b0;
    #(st ? STORE_NS : 100);
    if (st) nv = sram;
    else sram = nv;
    if (st) store_cnt_o++;
    else recall_cnt_o++;
    dirty = 1'b0;
    busy_n_o = 1'b1;
    xfer = 1'b0;
  endtask : nv_op
  // Supply trip: busy pulse, store only when written
  always @(posedge trip_i) begin
    #100 busy_n_o = 1'b0;
    #1000;
    if (dirty) nv_op(1'b1);
    else busy_n_o = 1'b1;
  end
endmodule : nvsc_dev_model
`default_nettype wire

// file: dv/nvsc_host_checker.sv
// Purpose: Pin-level checks on the nonvolatile SRAM host controller
// Assumes: Busy pin is pulled up outside; host never pulls it
// Notes: Bound from the bench top file
`timescale 1ns/100ps
`default_nettype none
module nvsc_host_checker (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Status and memory pins
  input wire logic ready_o,
  input wire logic [14:0] mem_addr_o,
  input wire logic mem_ce_n_o,
  input wire logic mem_we_n_o,
  input wire logic mem_oe_n_o,
  input wire logic [7:0] mem_dq_o,
  input wire logic mem_dq_oe_n_o,
  input wire logic hw_save_busy_n_i,
  input wire logic hw_save_busy_n_oe_n_o
);
  // One clock domain, so one default for all
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  a_read_ctl: assert property (!mem_oe_n_o |-> mem_we_n_o && !mem_ce_n_o)
    else $error("output enable low outside a read");
  a_write_ctl: assert property (!mem_we_n_o |-> mem_oe_n_o && !mem_dq_oe_n_o && !mem_ce_n_o)
    else $error("write without driven data or with output enable");
  a_addr_hold: assert property (!mem_ce_n_o && !$fell(mem_ce_n_o) |-> $stable(mem_addr_o))
    else $error("address moved inside a cycle");
  a_data_hold: assert property (!mem_we_n_o && !$fell(mem_we_n_o) |-> $stable(mem_dq_o))
    else $error("write data moved before the write ended");
  a_pulse_len: assert property ($fell(mem_ce_n_o) |-> !mem_ce_n_o [*6])
    else $error("chip enable pulse too short");
  a_ce_gap: assert property ($rose(mem_ce_n_o) |-> mem_ce_n_o [*2])
    else $error("chip enable pulses not separated");
  a_busy_hold: assert property ((!hw_save_busy_n_i) [*8] |-> !$fell(mem_ce_n_o))
    else $error("access started while device busy");
  a_busy_released: assert property (hw_save_busy_n_oe_n_o)
    else $error("host pulled the busy line");
  a_idle_pins: assert property (ready_o |-> mem_ce_n_o && mem_we_n_o && mem_dq_oe_n_o)
    else $error("idle with the memory selected");
  // Main scenarios reached
  c_write: cover property ($fell(mem_we_n_o));
  c_read: cover property ($fell(mem_oe_n_o));
  c_busy: cover property ($fell(hw_save_busy_n_i));
endmodule : nvsc_host_checker
`default_nettype wire

// file: dv/tb_nvsc_host.sv
// Purpose: Self-checking bench for the nonvolatile SRAM host
// Assumes: Shortened store, restore and recall waits
// Notes: Plain accesses from a table, transfers by hand
`timescale 1ns/100ps
`default_nettype none
module tb_nvsc_host;
  import nvsc_pkg::*;
  // Bench-driven inputs
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_i = 1'b0, req_we_i = 1'b0, sw_store_i = 1'b0, sw_recall_i = 1'b0, trip = 1'b0;
  logic [14:0] req_addr_i = 15'h0000;
  logic [7:0] req_wdata_i = 8'h00;
  // Design outputs and device side
  logic ready_o, done_o, nv_busy_o, mem_ce_n_o, mem_we_n_o, mem_oe_n_o, mem_dq_oe_n_o;
  logic hw_save_busy_n_o, hw_save_busy_n_oe_n_o, dev_busy_n;
  logic [7:0] rdata_o, mem_dq_o, mem_dq_i;
  logic [14:0] mem_addr_o;
  int n_store, n_recall;
  int errors = 0;
  int n_checks = 0;
  // Busy line: pull-up, device and host may pull down
  wire logic hw_save_busy_n_i = dev_busy_n & (hw_save_busy_n_oe_n_o | hw_save_busy_n_o);
  wire logic [7:0] dq_to_dev = mem_dq_oe_n_o ? ~mem_dq_o : mem_dq_o;
  // Rows: write flag, address, data or expected read data
  logic [23:0] rows [6] = '{24'hffffa5, 24'h812311, 24'hc12322, 24'h7fffa5, 24'h012311, 24'h412322};
  nvsc_host #(.STORE_CYC(50), .RESTORE_CYC(20), .RECALL_CYC(20)) dut (.clk_sys_i, .rst_n_i, .req_i,
    .req_we_i, .req_addr_i, .req_wdata_i, .sw_store_i, .sw_recall_i, .ready_o, .done_o, .rdata_o,
    .nv_busy_o, .mem_addr_o, .mem_ce_n_o, .mem_we_n_o, .mem_oe_n_o, .mem_dq_i, .mem_dq_o,
    .mem_dq_oe_n_o, .hw_save_busy_n_i, .hw_save_busy_n_o, .hw_save_busy_n_oe_n_o);
  nvsc_dev_model model (.ce_n_i(mem_ce_n_o), .we_n_i(mem_we_n_o), .oe_n_i(mem_oe_n_o), .addr_i(mem_addr_o),
    .dq_i(dq_to_dev), .trip_i(trip), .dq_o(mem_dq_i), .busy_n_o(dev_busy_n), .store_cnt_o(n_store),
    .recall_cnt_o(n_recall));
  // 125 MHz clock
  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // Compare and count
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task complete_run;
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  // Bounded wait for the completion pulse
  task automatic wait_done;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk_sys_i);
      if (done_o === 1'b1) return;
    end
    errors++;
    complete_run();
  endtask : wait_done
  // Kind 0 access, 1 software store, 2 software recall
  task automatic go(input logic [1:0] k, input logic [23:0] r);
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk_sys_i);
      if (ready_o === 1'b1) break;
    end
    // Never became ready: count it and report
    if (ready_o !== 1'b1) begin
      errors++;
      complete_run();
    end
    req_i <= (k == 2'd0);
    sw_store_i <= (k == 2'd1);
    sw_recall_i <= (k == 2'd2);
    req_we_i <= r[23];
    req_addr_i <= r[22:8];
    req_wdata_i <= r[7:0];
    @(posedge clk_sys_i);
    req_i <= 1'b0;
    sw_store_i <= 1'b0;
    sw_recall_i <= 1'b0;
    wait_done();
  endtask : go
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys_i);
    chk("idle_pins", 4'b0111, {ready_o, nv_busy_o, mem_ce_n_o, mem_we_n_o});
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    chk("we_n", 1'b1, mem_we_n_o);
    foreach (rows[i]) begin
      go(2'd0, rows[i]);
      if (!rows[i][23]) chk("rdata", rows[i][7:0], rdata_o);
    end
    // Power-up wait is over once plain accesses complete
    chk("nv_busy", 1'b0, nv_busy_o);
    go(2'd1, 24'h0);
    chk("store_cnt", 1, n_store);
    go(2'd1, 24'h0);
    chk("store_cnt", 2, n_store);
    go(2'd0, 24'h812399);
    go(2'd2, 24'h0);
    chk("recall_cnt", 1, n_recall);
    go(2'd0, 24'h012300);
    chk("rdata", 8'h11, rdata_o);
    trip <= 1'b1;
    wait_done();
    chk("store_cnt", 2, n_store);
    trip <= 1'b0;
    go(2'd0, 24'h800177);
    trip <= 1'b1;
    wait_done();
    chk("store_cnt", 3, n_store);
    go(2'd0, 24'h000100);
    chk("rdata", 8'h77, rdata_o);
    // Mid-run reset: pins idle, power-up wait again, array kept
    rst_n_i <= 1'b0;
    @(posedge clk_sys_i);
    chk("rst_pins", 4'b0111, {ready_o, nv_busy_o, mem_ce_n_o, mem_we_n_o});
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    go(2'd0, 24'h000100);
    chk("rdata", 8'h77, rdata_o);
    chk("nv_busy", 1'b0, nv_busy_o);
    complete_run();
  end
endmodule : tb_nvsc_host
bind nvsc_host nvsc_host_checker u_chk (.clk_sys_i, .rst_n_i, .ready_o, .mem_addr_o, .mem_ce_n_o, .mem_we_n_o,
  .mem_oe_n_o, .mem_dq_o, .mem_dq_oe_n_o, .hw_save_busy_n_i, .hw_save_busy_n_oe_n_o);
`default_nettype wire

// file: logic/nvsc_host.sv
// Purpose: Host controller driving a 32K x 8 nonvolatile SRAM over its pins
// Assumes: One user request at a time; the busy pin has an external pull-up
// Notes: Device timing taken from the slowest speed grade
`timescale 1ns/100ps
`default_nettype none
module nvsc_host
  import nvsc_pkg::*;
#(
  parameter int unsigned STORE_CYC = nvsc_pkg::CYC_STORE, // Shorten for simulation
  parameter int unsigned RESTORE_CYC = nvsc_pkg::CYC_RESTORE, // Shorten for simulation
  parameter int unsigned RECALL_CYC = nvsc_pkg::CYC_RECALL // Shorten for simulation
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // User request port
  input wire logic req_i, // One-cycle request pulse
  input wire logic req_we_i, // 1 = write
  input wire logic [nvsc_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [nvsc_pkg::DATA_W-1:0] req_wdata_i,
  input wire logic sw_store_i, // Pulse: run software store
  input wire logic sw_recall_i, // Pulse: run software recall
  output logic ready_o, // Idle and able to take a request
  output logic done_o, // Pulse at end of any request
  output logic [nvsc_pkg::DATA_W-1:0] rdata_o,
  output logic nv_busy_o, // Device busy seen or nonvolatile wait running
  // Memory pins
  output logic [nvsc_pkg::ADDR_W-1:0] mem_addr_o,
  output logic mem_ce_n_o,
  output logic mem_we_n_o,
  output logic mem_oe_n_o,
  input wire logic [nvsc_pkg::DATA_W-1:0] mem_dq_i,
  output logic [nvsc_pkg::DATA_W-1:0] mem_dq_o,
  output logic mem_dq_oe_n_o, // Low while host drives data
  input wire logic hw_save_busy_n_i, // Open-drain busy, read only here
  output logic hw_save_busy_n_o,
  output logic hw_save_busy_n_oe_n_o // Host never pulls busy: held high
);
  import nvsc_pkg::*;

  typedef enum logic [2:0] {S_POWERUP, S_IDLE, S_SETUP, S_PULSE, S_GAP, S_NVWAIT} nvsc_state_type;

  nvsc_state_type st_q, st_d; // Sequencer state
  logic [CNT_W-1:0] cnt_q, cnt_d; // Phase timer
  logic [2:0] step_q, step_d; // Unlock step, 0..5
  logic seq_q, seq_d; // Running an unlock sequence
  logic rcl_q, rcl_d; // Sequence ends in recall
  logic we_q, we_d; // Current access is a write
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;
  logic ce_n_q, ce_n_d, we_n_q, we_n_d, oe_n_q, oe_n_d, dqoe_n_q, dqoe_n_d;
  logic done_q, done_d;
  logic busy_n; // Synchronised busy level
  logic [13:0] seq_addr; // Address for current unlock step

  // Busy pin crosses in through four flip-flops
  nvsc_sync u_busy_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .pin_i(hw_save_busy_n_i),
    .level_o(busy_n)
  );

  // Unlock address table
  always_comb begin
    case (step_q)
      3'h0: seq_addr = SEQ_A0;
      3'h1: seq_addr = SEQ_A1;
      3'h2: seq_addr = SEQ_A2;
      3'h3: seq_addr = SEQ_A3;
      3'h4: seq_addr = SEQ_A4;
      default: seq_addr = rcl_q ? SEQ_RECALL : SEQ_STORE;
    endcase
  end

  // Next-state logic for the whole sequencer
  always_comb begin
    st_d = st_q;
    cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    step_d = step_q;
    seq_d = seq_q;
    rcl_d = rcl_q;
    we_d = we_q;
    addr_d = addr_q;
    wd_d = wd_q;
    rd_d = rd_q;
    ce_n_d = ce_n_q;
    we_n_d = we_n_q;
    oe_n_d = oe_n_q;
    dqoe_n_d = dqoe_n_q;
    done_d = 1'b0;
    case (st_q)
      // Wait out the power-up recall before any access
      S_POWERUP: begin
        if (cnt_q == '0 && busy_n) begin
          st_d = S_IDLE;
        end
      end
      S_IDLE: begin
        if (!busy_n) begin
          // Device storing: hold off all accesses
          st_d = S_NVWAIT;
          cnt_d = CNT_W'(CYC_BUSY);
        end else if (sw_store_i || sw_recall_i) begin
          seq_d = 1'b1;
          rcl_d = sw_recall_i && !sw_store_i;
          step_d = 3'h0;
          we_d = 1'b0;
          st_d = S_SETUP;
        end else if (req_i) begin
          seq_d = 1'b0;
          we_d = req_we_i;
          addr_d = req_addr_i;
          wd_d = req_wdata_i;
          st_d = S_SETUP;
        end
      end
      // Present address with enables high, one cycle of setup; unlock steps load their address on the edge that drops chip enable
      S_SETUP: begin
        if (seq_q) begin
          addr_d = {1'b0, seq_addr};
        end
        we_n_d = !we_q;
        oe_n_d = we_q;
        dqoe_n_d = !we_q;
        ce_n_d = 1'b0;
        cnt_d = CNT_W'(CYC_ACCESS > CYC_PULSE ? CYC_ACCESS : CYC_PULSE);
        st_d = S_PULSE;
      end
      // Chip enable low; address held still throughout
      S_PULSE: begin
        if (cnt_q == '0) begin
          rd_d = mem_dq_i;
          ce_n_d = 1'b1;
          we_n_d = 1'b1;
          oe_n_d = 1'b1;
          cnt_d = CNT_W'(CYC_GAP);
          st_d = S_GAP;
        end
      end
      // Release data after the terminating edge, then space cycles
      S_GAP: begin
        dqoe_n_d = 1'b1;
        if (cnt_q == '0) begin
          if (seq_q && step_q != 3'h5) begin
            // Back to back reads, nothing interleaved
            step_d = step_q + 3'h1;
            st_d = S_SETUP;
          end else if (seq_q) begin
            // Final read launched the transfer; store runs regardless of writes
            seq_d = 1'b0;
            cnt_d = rcl_q ? CNT_W'(RECALL_CYC) : CNT_W'(STORE_CYC);
            st_d = S_NVWAIT;
          end else begin
            done_d = 1'b1;
            st_d = S_IDLE;
          end
        end
      end
      // Transfer in progress: no SRAM access until timer and busy clear
      S_NVWAIT: begin
        if (cnt_q == '0 && busy_n) begin
          done_d = 1'b1;
          st_d = S_IDLE;
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  // Register stage
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= S_POWERUP;
      cnt_q <= CNT_W'(RESTORE_CYC);
      step_q <= 3'h0;
      seq_q <= 1'b0;
      rcl_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= '0;
      wd_q <= 8'h00;
      rd_q <= 8'h00;
      ce_n_q <= 1'b1;
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      dqoe_n_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      step_q <= step_d;
      seq_q <= seq_d;
      rcl_q <= rcl_d;
      we_q <= we_d;
      addr_q <= addr_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
      ce_n_q <= ce_n_d;
      we_n_q <= we_n_d;
      oe_n_q <= oe_n_d;
      dqoe_n_q <= dqoe_n_d;
      done_q <= done_d;
    end
  end

  // Status flops so every output but the tied busy pins is registered
  logic ready_q, nvb_q;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_q <= 1'b0;
      nvb_q <= 1'b1;
    end else begin
      ready_q <= (st_d == S_IDLE);
      nvb_q <= (st_d == S_NVWAIT) || (st_d == S_POWERUP);
    end
  end

  assign ready_o = ready_q;
  assign done_o = done_q;
  assign rdata_o = rd_q;
  assign nv_busy_o = nvb_q;
  assign mem_addr_o = addr_q;
  assign mem_ce_n_o = ce_n_q;
  assign mem_we_n_o = we_n_q;
  assign mem_oe_n_o = oe_n_q;
  assign mem_dq_o = wd_q;
  assign mem_dq_oe_n_o = dqoe_n_q;
  assign hw_save_busy_n_o = 1'b1;
  assign hw_save_busy_n_oe_n_o = 1'b1;
endmodule : nvsc_host
`default_nettype wire

// file: logic/nvsc_pkg.sv
// Purpose: Constants for the host-side controller of a 32K x 8 nonvolatile SRAM
// Assumes: 125 MHz system clock, all memory pins driven or sampled by the host
// Notes: Times are kept in their printed units; cycle counts derive from them
package nvsc_pkg;
  localparam int unsigned CLK_MHZ = 125; // System clock rate
  localparam int unsigned ADDR_W = 15; // Address pins
  localparam int unsigned SEQ_ADDR_W = 14; // Bits that steer software modes
  localparam int unsigned DATA_W = 8; // Data pins
  // Unlock sequence addresses
  localparam logic [13:0] SEQ_A0 = 14'h0e38;
  localparam logic [13:0] SEQ_A1 = 14'h31c7;
  localparam logic [13:0] SEQ_A2 = 14'h03e0;
  localparam logic [13:0] SEQ_A3 = 14'h3c1f;
  localparam logic [13:0] SEQ_A4 = 14'h303f;
  localparam logic [13:0] SEQ_STORE = 14'h0fc0;
  localparam logic [13:0] SEQ_RECALL = 14'h0c63;
  // Access timing in ns (slowest grade, safe for all)
  localparam int unsigned T_CYCLE_NS = 55; // Read/write cycle time
  localparam int unsigned T_PULSE_NS = 45; // Enable low width
  localparam int unsigned T_ACCESS_NS = 55; // Enable to data valid
  localparam int unsigned CYC_PULSE = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_ACCESS = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_GAP = ((T_CYCLE_NS - T_PULSE_NS) * CLK_MHZ + 999) / 1000 + 1;
  // Nonvolatile timing
  localparam int unsigned T_STORE_US = 10000; // Store duration, max
  localparam int unsigned T_RECALL_US = 20; // Software recall duration, max
  localparam int unsigned T_RESTORE_US = 550; // Power-up recall duration, max
  localparam int unsigned T_DELAY_US = 1; // Time allowed for SRAM cycle
  localparam int unsigned T_BUSY_NS = 300; // Trigger to busy low, max
  localparam int unsigned CYC_STORE = T_STORE_US * CLK_MHZ;
  localparam int unsigned CYC_RECALL = T_RECALL_US * CLK_MHZ;
  localparam int unsigned CYC_RESTORE = T_RESTORE_US * CLK_MHZ;
  localparam int unsigned CYC_DELAY = T_DELAY_US * CLK_MHZ;
  localparam int unsigned CYC_BUSY = (T_BUSY_NS * CLK_MHZ) / 1000;
  localparam int unsigned CNT_W = 24; // Wait counter width
endpackage : nvsc_pkg

// file: logic/nvsc_sync.sv
// Purpose: Three-stage synchroniser for one pin input
// Assumes: Input is asynchronous to clk_sys_i
// Notes: A change counts once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module nvsc_sync (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Pin and filtered level
  input wire logic pin_i,
  output logic level_o
);
  logic s1_q, s2_q, s3_q; // Stage chain
  logic lvl_q; // Filtered level
  logic lvl_d;

  // Filtered level only moves when stages two and three agree
  always_comb begin
    lvl_d = (s2_q == s3_q) ? s2_q : lvl_q;
  end

  // Chain; asynchronous reset loads constant ones (idle pin level)
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      lvl_q <= 1'b1;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level_o = lvl_q;
endmodule : nvsc_sync
`default_nettype wire
